// ---- tcc_timer.sv ----
// Top of one 16-bit up-counting timer/event counter channel.
// Assumes a single-cycle register port master and asynchronous pins.
`timescale 1ns/10ps

module tcc_timer (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Timer pins
  input  wire logic        timer_input_a_i,
  input  wire logic        timer_input_b_i,
  input  wire logic        count_clk_i,
  output logic             timer_output_o,
  // Interrupt request pulses
  output logic             match_a_irq_o,
  output logic             match_b_irq_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // Asynchronous assert, two-stage release
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_raw = {count_clk_i, timer_input_b_i, timer_input_a_i};

  // Three stages; a level is accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic [tcc_pkg::SYNC_STAGES-1:0] sync;
      logic                            level;
      logic                            next_level;
      always_comb begin
        next_level = (sync[1] == sync[2]) ? sync[2] : level;
      end
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          sync  <= 3'h0;
          level <= 1'b0;
        end else begin
          sync  <= {sync[1:0], pin_raw[gi]};
          level <= next_level;
        end
      end
      assign pin_level[gi] = level;
      assign pin_rise[gi]  = next_level & ~level;
      assign pin_fall[gi]  = ~next_level & level;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]          count;
  logic [15:0]          next_count;
  logic [15:0]          cc_a;
  logic [15:0]          next_cc_a;
  logic [15:0]          cc_b;
  logic [15:0]          next_cc_b;
  tcc_pkg::tcc_mode_t   mode;
  tcc_pkg::tcc_mode_t   next_mode;
  tcc_pkg::tcc_ccctl_t  ccctl;
  tcc_pkg::tcc_ccctl_t  next_ccctl;
  tcc_pkg::tcc_outctl_t outctl;
  tcc_pkg::tcc_outctl_t next_outctl;
  tcc_pkg::tcc_edge_t   edgectl;
  tcc_pkg::tcc_edge_t   next_edgectl;
  logic                 tout;
  logic                 next_tout;
  logic                 irq_a;
  logic                 next_irq_a;
  logic                 irq_b;
  logic                 next_irq_b;
  logic [31:0]          rdata;
  logic [31:0]          next_rdata;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  logic running;
  logic tick;
  logic edge_a_valid;
  logic edge_a_opp;
  logic edge_b_valid;
  logic match_a;
  logic match_b;
  logic oneshot_trig;
  logic wr_mode;

  // Valid edge of an input per its two-bit select; reserved code gives none
  function automatic logic valid_edge(input logic [1:0] sel, input logic r, input logic f);
    valid_edge = (sel == tcc_pkg::EDGE_RISE) ? r :
                 (sel == tcc_pkg::EDGE_FALL) ? f :
                 (sel == tcc_pkg::EDGE_BOTH) ? (r | f) : 1'b0;
  endfunction

  // Opposite phase of input A; none when both edges are valid
  function automatic logic opp_edge(input logic [1:0] sel, input logic r, input logic f);
    opp_edge = (sel == tcc_pkg::EDGE_RISE) ? f :
               (sel == tcc_pkg::EDGE_FALL) ? r : 1'b0;
  endfunction

  assign running      = (mode.run_mode != tcc_pkg::RUN_STOP);
  // Internal tick is every core cycle; external tick is a rising count pin
  assign tick         = running & (edgectl.ext_count ? pin_rise[2] : 1'b1);
  assign edge_a_valid = running & valid_edge(edgectl.edge_a, pin_rise[0], pin_fall[0]);
  assign edge_a_opp   = running & opp_edge(edgectl.edge_a, pin_rise[0], pin_fall[0]);
  assign edge_b_valid = running & valid_edge(edgectl.edge_b, pin_rise[1], pin_fall[1]);
  // Match is taken as the counter steps off the compare value, so a
  // compare of zero cannot fire at start, only on the 0-to-1 step
  assign match_a      = tick & ~ccctl.a_capture & (count == cc_a);
  assign match_b      = tick & ~ccctl.b_capture & (count == cc_b);
  assign wr_mode      = reg_wr_i & (reg_addr_i == tcc_pkg::ADDR_MODE_CTRL);
  assign oneshot_trig = reg_wr_i & (reg_addr_i == tcc_pkg::ADDR_OUTPUT_CTRL)
                      & reg_wdata_i[tcc_pkg::OSPT_BIT];

  // ----------------------------------------------------------------
  // Counter and overflow
  // ----------------------------------------------------------------
  logic clear_cnt;

  // Clear sources depend on run mode and one-shot mode
  always_comb begin
    clear_cnt = 1'b0;
    case (mode.run_mode)
      tcc_pkg::RUN_CLR_EDGE:  clear_cnt = edge_a_valid;
      tcc_pkg::RUN_CLR_MATCH: clear_cnt = tick & (count == cc_a);
      default:                clear_cnt = 1'b0;
    endcase
    if (running && outctl.oneshot_mode && (oneshot_trig || edge_a_valid)) begin
      clear_cnt = 1'b1;
    end
  end

  // Next count and control registers
  always_comb begin
    next_count   = count;
    next_mode    = mode;
    next_ccctl   = ccctl;
    next_outctl  = outctl;
    next_edgectl = edgectl;
    if (!running) begin
      next_count = tcc_pkg::COUNT_RESET;
    end else if (clear_cnt) begin
      next_count = tcc_pkg::COUNT_RESET;
    end else if (tick) begin
      next_count = count + 16'h0001;
    end
    if (wr_mode) begin
      next_mode.run_mode       = tcc_pkg::tcc_run_t'(reg_wdata_i[3:2]);
      next_mode.toggle_on_edge = reg_wdata_i[1];
      next_mode.overflow_flag  = reg_wdata_i[0];
    end
    if (wr_mode && (reg_wdata_i[3:2] == tcc_pkg::RUN_STOP)) begin
      next_count              = tcc_pkg::COUNT_RESET;
      next_mode.overflow_flag = 1'b0;
    end
    // Any step off FFFF (count or clear) sets the flag; beats a software clear
    if ((tick || clear_cnt) && (count == tcc_pkg::COUNT_MAX)) begin
      next_mode.overflow_flag = 1'b1;
    end
    if (reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_CAPCOMP_CTRL)) begin
      next_ccctl = tcc_pkg::tcc_ccctl_t'(reg_wdata_i[2:0]);
    end
    if (reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_OUTPUT_CTRL)) begin
      next_outctl = tcc_pkg::tcc_outctl_t'(reg_wdata_i[3:1]);
    end
    if (reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_EDGE_CTRL)) begin
      next_edgectl = tcc_pkg::tcc_edge_t'(reg_wdata_i[4:0]);
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare registers and interrupts
  // ----------------------------------------------------------------
  // Hardware capture wins over a software write in the same cycle;
  // a capture racing a stop write takes whatever count is live
  always_comb begin
    next_cc_a  = cc_a;
    next_cc_b  = cc_b;
    next_irq_a = match_a;
    next_irq_b = match_b;
    if (reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_CAPCOMP_A)) begin
      next_cc_a = reg_wdata_i[15:0];
    end
    if (reg_wr_i && (reg_addr_i == tcc_pkg::ADDR_CAPCOMP_B)) begin
      next_cc_b = reg_wdata_i[15:0];
    end
    if (ccctl.a_capture) begin
      if (ccctl.capture_a_source_select) begin
        if (edge_a_opp) begin
          next_cc_a = count;
        end
        next_irq_a = edge_b_valid;
      end else begin
        if (edge_b_valid) begin
          next_cc_a = count;
        end
        next_irq_a = edge_b_valid;
      end
    end
    // Source select for A plays no part here
    if (ccctl.b_capture) begin
      if (edge_a_valid) begin
        next_cc_b = count;
      end
      next_irq_b = edge_a_valid;
    end
  end

  // ----------------------------------------------------------------
  // Timer output
  // ----------------------------------------------------------------
  // Toggles on compare matches, and on input A edges if enabled
  always_comb begin
    next_tout = tout;
    if (!outctl.out_enable || !running) begin
      next_tout = outctl.init_level;
    end else if (match_a || match_b || (mode.toggle_on_edge && edge_a_valid)) begin
      next_tout = ~tout;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read zero; data stands only in the next cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        tcc_pkg::ADDR_TIMER_COUNT:  next_rdata = {16'h0000, running ? count : 16'h0000};
        tcc_pkg::ADDR_CAPCOMP_A:    next_rdata = {16'h0000, cc_a};
        tcc_pkg::ADDR_CAPCOMP_B:    next_rdata = {16'h0000, cc_b};
        tcc_pkg::ADDR_MODE_CTRL:    next_rdata = {28'h0000000, mode};
        tcc_pkg::ADDR_CAPCOMP_CTRL: next_rdata = {29'h00000000, ccctl};
        tcc_pkg::ADDR_OUTPUT_CTRL:  next_rdata = {28'h0000000, outctl, 1'b0};
        tcc_pkg::ADDR_EDGE_CTRL:    next_rdata = {27'h0000000, edgectl};
        default:                    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count   <= tcc_pkg::COUNT_RESET;
      cc_a    <= tcc_pkg::CC_RESET;
      cc_b    <= tcc_pkg::CC_RESET;
      mode    <= tcc_pkg::tcc_mode_t'(tcc_pkg::MODE_RESET);
      ccctl   <= tcc_pkg::tcc_ccctl_t'(tcc_pkg::CCCTL_RESET);
      outctl  <= tcc_pkg::tcc_outctl_t'(tcc_pkg::OUTCTL_RESET);
      edgectl <= tcc_pkg::tcc_edge_t'(tcc_pkg::EDGE_RESET);
      tout    <= 1'b0;
      irq_a   <= 1'b0;
      irq_b   <= 1'b0;
      rdata   <= 32'h0000_0000;
    end else begin
      count   <= next_count;
      cc_a    <= next_cc_a;
      cc_b    <= next_cc_b;
      mode    <= next_mode;
      ccctl   <= next_ccctl;
      outctl  <= next_outctl;
      edgectl <= next_edgectl;
      tout    <= next_tout;
      irq_a   <= next_irq_a;
      irq_b   <= next_irq_b;
      rdata   <= next_rdata;
    end
  end

  assign reg_rdata_o    = rdata;
  assign timer_output_o = tout;
  assign match_a_irq_o  = irq_a;
  assign match_b_irq_o  = irq_b;

endmodule

// ---- tcc_pkg.sv ----
// Package for the 16-bit capture/compare timer channel.
// Assumes a 32-bit register port with byte addresses, one word per register.
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_COUNT  = 8'h00;
  localparam logic [7:0] ADDR_CAPCOMP_A    = 8'h04;
  localparam logic [7:0] ADDR_CAPCOMP_B    = 8'h08;
  localparam logic [7:0] ADDR_MODE_CTRL    = 8'h0c;
  localparam logic [7:0] ADDR_CAPCOMP_CTRL = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_EDGE_CTRL    = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [15:0] CC_RESET    = 16'h0000;
  localparam int          SYNC_STAGES = 3;

  // Run mode field encodings
  typedef enum logic [1:0] {
    RUN_STOP      = 2'h0,
    RUN_FREE      = 2'h1,
    RUN_CLR_EDGE  = 2'h2,
    RUN_CLR_MATCH = 2'h3
  } tcc_run_t;

  // Valid edge encodings for the timer inputs
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // mode_control_reg: [3:2] run mode, [1] toggle on input A edge, [0] overflow
  typedef struct packed {
    tcc_run_t run_mode;
    logic     toggle_on_edge;
    logic     overflow_flag;
  } tcc_mode_t;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // capcomp_control_reg: [2] B capture, [1] A source select, [0] A capture
  typedef struct packed {
    logic b_capture;
    logic capture_a_source_select;
    logic a_capture;
  } tcc_ccctl_t;
  localparam logic [2:0] CCCTL_RESET = 3'h0;

  // output_control_reg: [3] initial level, [2] output enable, [1] one-shot mode
  // Bit 0 is the one-shot trigger; it is write-only and reads as zero.
  typedef struct packed {
    logic init_level;
    logic out_enable;
    logic oneshot_mode;
  } tcc_outctl_t;
  localparam logic [2:0] OUTCTL_RESET = 3'h0;
  localparam int         OSPT_BIT     = 0;

  // edge control: [4] external count clock, [3:2] input B edge, [1:0] input A edge
  typedef struct packed {
    logic       ext_count;
    logic [1:0] edge_b;
    logic [1:0] edge_a;
  } tcc_edge_t;
  localparam logic [4:0] EDGE_RESET = 5'h00;

endpackage

// ---- tcc_timer_assertions.sv ----
// Port-level assertions for the timer channel.
// Assumes register A is a compare register whenever run mode 01 starts.
`timescale 1ns/10ps
module tcc_timer_assertions (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  // Register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Interrupt pulses
  input wire logic        match_a_irq_o,
  input wire logic        match_b_irq_o
);
  logic [1:0]  run_q;
  logic [15:0] cca_q;

  // Shadow copies, since internal state is out of sight
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 2'h0;
      cca_q <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == tcc_pkg::ADDR_MODE_CTRL) begin
      run_q <= reg_wdata_i[3:2];
    end else if (reg_wr_i && reg_addr_i == tcc_pkg::ADDR_CAPCOMP_A) begin
      cca_q <= reg_wdata_i[15:0];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Free run started from stop with a known compare value
  sequence s_start(logic [15:0] v);
    reg_wr_i && reg_addr_i == tcc_pkg::ADDR_MODE_CTRL && reg_wdata_i[3:2] == 2'h1
      && run_q == 2'h0 && cca_q == v;
  endsequence
  sequence s_third_tick;
    !match_a_irq_o [*3] ##1 match_a_irq_o;
  endsequence

  property p_first; s_start(16'h0002) |-> ##1 s_third_tick; endproperty
  a_first: assert property (p_first) else $error("first match A mistimed");
  property p_zero; s_start(16'h0000) |-> ##1 !match_a_irq_o ##1 match_a_irq_o; endproperty
  a_zero: assert property (p_zero) else $error("zero compare mistimed");
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_stop_rd;
    reg_rd_i && reg_addr_i == tcc_pkg::ADDR_TIMER_COUNT && run_q == 2'h0 |=> reg_rdata_o == 32'h0;
  endproperty
  a_stop_rd: assert property (p_stop_rd) else $error("stopped count not zero");
  property p_quiet;
    run_q == 2'h0 && $past(run_q) == 2'h0 && $past(run_q, 2) == 2'h0 |-> !match_a_irq_o && !match_b_irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event while stopped");
  property p_pulse_a; match_a_irq_o && run_q != 2'h3 |=> !match_a_irq_o; endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("irq A longer than a pulse");
  property p_pulse_b; match_b_irq_o && run_q != 2'h3 |=> !match_b_irq_o; endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("irq B longer than a pulse");
  // Escape term: a stop write may cut the period short
  property p_period;
    match_a_irq_o && run_q == 2'h3 && cca_q == 16'h0003 |-> ##4 (match_a_irq_o || run_q != 2'h3);
  endproperty
  a_period: assert property (p_period) else $error("match clear period wrong");
endmodule

// ---- tcc_pin_model.sv ----
// Model of the pins around the timer: inputs A and B and count clock.
// Assumes one caller at a time; holds each level long enough for the filter.
`timescale 1ns/10ps
module tcc_pin_model (
  // Clock
  input  wire logic core_clk_i,
  // Pins toward the timer
  output logic      pin_a_o,
  output logic      pin_b_o,
  output logic      count_clk_o
);
  // Driven pins idle low
  initial begin
    pin_a_o     = 1'b0;
    pin_b_o     = 1'b0;
    count_clk_o = 1'b0;
  end

  // Short holds would be filtered out as noise
  task automatic set_pin(input int sel, input logic lvl, input int hold);
    @(posedge core_clk_i);
    if (sel == 0) pin_a_o <= lvl;
    else if (sel == 1) pin_b_o <= lvl;
    else count_clk_o <= lvl;
    repeat (hold) @(posedge core_clk_i);
    #1;
  endtask
endmodule

// ---- tcc_timer_tb_top.sv ----
// Self-checking bench for the timer channel.
// Assumes package, timer, pin model and checker compile first.
`timescale 1ns/10ps
module tcc_timer_tb_top;
  logic        core_clk;
  logic        reset_n = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] rdata;
  logic        pin_a;
  logic        pin_b;
  logic        cnt_clk;
  logic        tout;
  logic        irq_a;
  logic        irq_b;
  logic [31:0] d;
  logic [31:0] e;
  int          err_total;
  int          num_checks;
  int          n_a;
  int          n_b;
  int          cycles;
  int          a0;
  int          b0;

  tcc_timer tcc_timer_i (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .timer_input_a_i(pin_a),
    .timer_input_b_i(pin_b), .count_clk_i(cnt_clk), .timer_output_o(tout),
    .match_a_irq_o(irq_a), .match_b_irq_o(irq_b)
  );
  tcc_pin_model tcc_pin_model_i (
    .core_clk_i(core_clk), .pin_a_o(pin_a), .pin_b_o(pin_b), .count_clk_o(cnt_clk)
  );

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pulse tally and hang guard; the overflow run alone needs 65536 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (irq_a === 1'b1) n_a <= n_a + 1;
    if (irq_b === 1'b1) n_b <= n_b + 1;
    if (cycles == 70000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    rreg(a, d);
    chk(d, exp, msg);
  endtask
  task automatic run(input logic [31:0] m);
    wreg(tcc_pkg::ADDR_MODE_CTRL, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pin(input int s, input logic l, input int h);
    tcc_pin_model_i.set_pin(s, l, h);
  endtask

  // Reset values, width, read-only count, unmapped place, idle level
  task automatic t_regs();
    rchk(tcc_pkg::ADDR_TIMER_COUNT, 32'h0, "count reset");
    rchk(tcc_pkg::ADDR_CAPCOMP_A, 32'h0, "a reset");
    rchk(tcc_pkg::ADDR_CAPCOMP_B, 32'h0, "b reset");
    wreg(tcc_pkg::ADDR_CAPCOMP_B, 32'hffff_8001);
    rchk(tcc_pkg::ADDR_CAPCOMP_B, 32'h8001, "b width");
    wreg(tcc_pkg::ADDR_TIMER_COUNT, 32'h1234);
    rchk(tcc_pkg::ADDR_TIMER_COUNT, 32'h0, "count written");
    rchk(8'h1c, 32'h0, "unmapped");
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h8);
    tick(2);
    chk({31'h0, tout}, 32'h1, "idle level");
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h0);
  endtask

  // Free run: count steps, one match per compare, compare zero included
  task automatic t_free();
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h4);
    for (int v = 0; v < 3; v += 2) begin
      wreg(tcc_pkg::ADDR_CAPCOMP_A, 32'(v));
      wreg(tcc_pkg::ADDR_CAPCOMP_B, 32'h5);
      a0 = n_a;
      b0 = n_b;
      run(32'h4);
      rreg(tcc_pkg::ADDR_TIMER_COUNT, d);
      rreg(tcc_pkg::ADDR_TIMER_COUNT, e);
      chk(e - d, 32'h2, "count step");
      chk({31'h0, tout}, 32'h1, "toggle on first match");
      tick(8);
      chk(32'(n_a - a0), 32'h1, "match a");
      chk(32'(n_b - b0), 32'h1, "match b");
      chk({31'h0, tout}, 32'h0, "toggle on match b");
      run(32'h0);
      rchk(tcc_pkg::ADDR_TIMER_COUNT, 32'h0, "stop clears");
      rchk(tcc_pkg::ADDR_CAPCOMP_A, 32'(v), "compare held");
    end
  endtask

  // Clear on match keeps the count within 0..3
  task automatic t_clr();
    wreg(tcc_pkg::ADDR_CAPCOMP_A, 32'h3);
    wreg(tcc_pkg::ADDR_CAPCOMP_B, 32'h2);
    run(32'hc);
    tick(6);
    for (int i = 0; i < 4; i++) begin
      rreg(tcc_pkg::ADDR_TIMER_COUNT, d);
      chk({31'h0, d < 32'h4}, 32'h1, "match clear");
    end
    run(32'h0);
  endtask

  // Captures into B on A edge, into A on B edge and on opposite A edge
  task automatic t_cap();
    wreg(tcc_pkg::ADDR_CAPCOMP_A, 32'h100);
    wreg(tcc_pkg::ADDR_EDGE_CTRL, 32'h5);
    for (int s = 0; s < 2; s++) begin
      wreg(tcc_pkg::ADDR_CAPCOMP_CTRL, 32'h4 | 32'(s) << 1);
      run(32'h4);
      tick(10);
      b0 = n_b;
      pin(0, 1'b1, 8);
      chk(32'(n_b - b0), 32'h1, "b capture event");
      rreg(tcc_pkg::ADDR_CAPCOMP_B, e);
      chk({31'h0, e > 32'h8}, 32'h1, "b captured");
      run(32'h0);
      rchk(tcc_pkg::ADDR_CAPCOMP_B, e, "b held");
      pin(0, 1'b0, 4);
    end
    wreg(tcc_pkg::ADDR_CAPCOMP_CTRL, 32'h1);
    run(32'h4);
    a0 = n_a;
    pin(1, 1'b1, 8);
    chk(32'(n_a - a0), 32'h1, "a capture event");
    rreg(tcc_pkg::ADDR_CAPCOMP_A, d);
    chk({31'h0, d < 32'h20}, 32'h1, "a captured");
    run(32'h0);
    wreg(tcc_pkg::ADDR_CAPCOMP_CTRL, 32'h3);
    run(32'h4);
    pin(1, 1'b0, 4);
    tick(20);
    a0 = n_a;
    pin(0, 1'b1, 8);
    pin(0, 1'b0, 8);
    rreg(tcc_pkg::ADDR_CAPCOMP_A, e);
    chk({31'h0, e > d}, 32'h1, "opposite capture");
    pin(1, 1'b1, 8);
    chk(32'(n_a - a0), 32'h1, "silent capture");
    rchk(tcc_pkg::ADDR_CAPCOMP_A, e, "b edge no capture");
    run(32'h0);
    pin(1, 1'b0, 4);
  endtask

  // Clears on input A edge and on one-shot trigger
  task automatic t_clear();
    wreg(tcc_pkg::ADDR_CAPCOMP_B, 32'hfff0);
    run(32'ha);
    tick(30);
    chk({31'h0, tout}, 32'h0, "no toggle before edge");
    pin(0, 1'b1, 8);
    rreg(tcc_pkg::ADDR_TIMER_COUNT, d);
    chk({31'h0, d < 32'hc}, 32'h1, "edge clear");
    chk({31'h0, tout}, 32'h1, "toggle on input edge");
    run(32'h0);
    pin(0, 1'b0, 4);
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h2);
    run(32'h4);
    tick(30);
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h3);
    rreg(tcc_pkg::ADDR_TIMER_COUNT, d);
    chk({31'h0, d < 32'h8}, 32'h1, "one-shot clear");
    run(32'h0);
    wreg(tcc_pkg::ADDR_OUTPUT_CTRL, 32'h0);
  endtask

  // Full wrap sets overflow; stop clears it; then external count clock
  task automatic t_ovf_ext();
    run(32'h4);
    tick(65540);
    rchk(tcc_pkg::ADDR_MODE_CTRL, 32'h5, "overflow");
    run(32'h0);
    rchk(tcc_pkg::ADDR_MODE_CTRL, 32'h0, "mode stopped");
    wreg(tcc_pkg::ADDR_EDGE_CTRL, 32'h10);
    run(32'h4);
    for (int i = 0; i < 3; i++) begin
      pin(2, 1'b1, 4);
      pin(2, 1'b0, 4);
    end
    rchk(tcc_pkg::ADDR_TIMER_COUNT, 32'h3, "external count");
  endtask

  // Reset for three cycles, then each scenario
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    tick(6);
    t_regs();
    t_free();
    t_clr();
    t_cap();
    t_clear();
    t_ovf_ext();
    final_report();
  end
endmodule

bind tcc_timer tcc_timer_assertions tcc_timer_assertions_i (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o)
);
